// ==== core_mem_control.sv ====
// Word-memory controller: arbitration, multiplexing, parity and cycle timing.
// Assumes request pins are asynchronous and the storage module answers in time.
`timescale 1ns/1ps
`default_nettype none
module core_mem_control
  import core_mem_pkg::*;
#(
  parameter int N = PORTS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Requesters
  input wire logic [N-1:0] req,
  input wire logic [N-1:0] req_write,
  input wire logic [N*ADDR_W-1:0] req_addr,
  input wire logic [N*DATA_W-1:0] req_wdata,
  output logic [N-1:0] grant,
  output logic [N-1:0] data_ready,
  output logic [N-1:0] release_pulse,
  output logic [DATA_W-1:0] read_data,
  // Configuration and status
  input wire logic [BANK_W-1:0] banks_installed,
  input wire logic halt_on_parity,
  input wire logic supply_fail,
  input wire logic parity_clear,
  output logic parity_error,
  output logic jump_if_no_parity_fault,
  output logic stop_sequencing,
  // Storage module
  output logic mem_start,
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_word_drive,
  output logic [WORD_W-1:0] mem_bit_drive,
  input wire logic [WORD_W-1:0] mem_sense
);
  typedef enum logic [1:0] {IDLE, GRANT, RUN} phase_t;
  phase_t phase;
  logic [N-1:0] req_s1, req_s2, pick, owner;
  logic any;
  logic [WORD_W-1:0] sense_s1, sense_s2, data_reg;
  logic [DIV_W-1:0] div;
  logic [TICK_W-1:0] tick;
  logic [1:0] power_ok;
  logic strobe, owner_write, parity_bad;
  logic [ADDR_W-1:0] sel_addr, wrap_addr, limit;
  logic [DATA_W-1:0] sel_data;
  logic supply_s1, supply_s2;
  logic [1:0] settle;
  logic last_tick;

  // Two-stage synchronisers for the pins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      req_s1 <= '0;
      req_s2 <= '0;
      sense_s1 <= '0;
      sense_s2 <= '0;
      supply_s1 <= 1'b0;
      supply_s2 <= 1'b0;
    end else begin
      req_s1 <= req;
      req_s2 <= req_s1;
      sense_s1 <= mem_sense;
      sense_s2 <= sense_s1;
      supply_s1 <= supply_fail;
      supply_s2 <= supply_s1;
    end
  end

  core_mem_arbiter #(.N(N)) core_mem_arbiter_i (
    .req(req_s2),
    .pick(pick),
    .any(any)
  );

  // Mux the owner's address and data
  always_comb begin
    sel_addr = '0;
    sel_data = '0;
    owner_write = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (owner[i]) begin
        sel_addr = req_addr[i*ADDR_W +: ADDR_W];
        sel_data = req_wdata[i*DATA_W +: DATA_W];
        owner_write = req_write[i];
      end
    end
  end

  // Wrap to installed size: 1 to 8 banks of 4096 words
  always_comb begin
    limit = ADDR_W'(BANK_WORDS) * ADDR_W'(banks_installed == '0 ? 1 :
      (banks_installed > BANK_W'(MAX_BANKS) ? MAX_BANKS : banks_installed));
    wrap_addr = (banks_installed >= BANK_W'(MAX_BANKS)) ? sel_addr
      : ADDR_W'(sel_addr % limit);
  end

  // 10 MHz memory-clock tick derived from sys_clk
  always_ff @(posedge sys_clk) begin
    if (rst || phase != RUN) begin
      div <= '0;
    end else if (div == DIV_LAST) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end
  assign strobe = (phase == RUN) && (div == DIV_LAST);

  // The synchronised request lags its pin by two edges, so a requester that
  // drops its line at release still looks busy here; hold off for that long
  assign last_tick = strobe && (tick == TICK_LAST);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      settle <= '0;
    end else begin
      settle <= {settle[0], last_tick};
    end
  end

  // Cycle sequencer
  // Grant stands from arbitration until release; one owner at a time
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase <= IDLE;
      owner <= '0;
      tick <= TICK_ZERO;
      grant <= '0;
      mem_start <= 1'b0;
      mem_addr <= '0;
    end else begin
      mem_start <= 1'b0;
      unique case (phase)
        IDLE: begin
          if (any && settle == '0) begin
            owner <= pick;
            grant <= pick;
            phase <= GRANT;
          end
        end
        GRANT: begin
          mem_addr <= wrap_addr;
          mem_start <= 1'b1;
          tick <= TICK_ZERO;
          phase <= RUN;
        end
        RUN: begin
          if (strobe) begin
            if (tick == TICK_LAST) begin
              phase <= IDLE;
              grant <= '0;
              owner <= '0;
            end else begin
              tick <= tick + 1'b1;
            end
          end
        end
        default: begin
          // Code 3 is never entered; fall back to idle rather than lock up
          phase <= IDLE;
          grant <= '0;
          owner <= '0;
        end
      endcase
    end
  end

  // Power-on hold: word drive stays off until the counter saturates, so a
  // supply that flickers back on cannot fire a half-driven word select
  always_ff @(posedge sys_clk) begin
    if (rst || supply_s2) begin
      power_ok <= '0;
    end else if (!(&power_ok)) begin
      power_ok <= power_ok + 1'b1;
    end
  end

  // Data register and storage drives
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      data_reg <= '0;
      mem_word_drive <= 1'b0;
      mem_bit_drive <= '0;
    end else begin
      if (strobe && tick == TICK_SENSE) begin
        if (owner_write) begin
          data_reg <= {~^sel_data, sel_data};
        end else begin
          data_reg <= sense_s2;
        end
      end
      mem_word_drive <= (phase == RUN) && (&power_ok) && !supply_s2;
      mem_bit_drive <= (phase == RUN && tick > TICK_SENSE) ? data_reg : '0;
    end
  end

  assign parity_bad = ~^sense_s2;

  // Read answer, release and parity status
  // A parity error in the clearing cycle wins, so it cannot slip past
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      data_ready <= '0;
      release_pulse <= '0;
      read_data <= '0;
      parity_error <= 1'b0;
      jump_if_no_parity_fault <= 1'b1;
      stop_sequencing <= 1'b0;
    end else begin
      data_ready <= '0;
      release_pulse <= '0;
      if (strobe && tick == TICK_SENSE && !owner_write) begin
        read_data <= sense_s2[DATA_W-1:0];
        data_ready <= owner;
      end
      if (strobe && tick == TICK_LAST) begin
        release_pulse <= owner;
      end
      if (strobe && tick == TICK_SENSE && !owner_write && parity_bad) begin
        parity_error <= 1'b1;
        jump_if_no_parity_fault <= 1'b0;
        stop_sequencing <= stop_sequencing | halt_on_parity;
      end else if (parity_clear) begin
        parity_error <= 1'b0;
        jump_if_no_parity_fault <= 1'b1;
        stop_sequencing <= 1'b0;
      end
    end
  end

  // Arbitration and cycle framing
  chk_grant_onehot: assert property (@(posedge sys_clk) disable iff (rst)
    $onehot0(grant))
    else $error("more than one grant");
  chk_idle_no_start: assert property (@(posedge sys_clk) disable iff (rst)
    mem_start |-> $past(phase) == GRANT && $past(grant) != '0)
    else $error("start without grant");
  chk_grant_held: assert property (@(posedge sys_clk) disable iff (rst)
    (grant != '0) && ($past(grant) != '0) |-> grant == $past(grant))
    else $error("grant moved mid-cycle");
  chk_settle_gap: assert property (@(posedge sys_clk) disable iff (rst)
    (release_pulse != '0) |-> (grant == '0) [*3])
    else $error("grant before requests settled");
  chk_idle_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    (grant == '0) |=> !mem_word_drive)
    else $error("word drive while idle");
  chk_start_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    mem_start |=> !mem_start)
    else $error("long start");
  chk_cycle_length: assert property (@(posedge sys_clk) disable iff (rst)
    mem_start |-> ##160 (release_pulse != '0))
    else $error("cycle not 1.6 us");
  chk_release_once: assert property (@(posedge sys_clk) disable iff (rst)
    (release_pulse != '0) |=> release_pulse == '0)
    else $error("long release");
  chk_release_owner: assert property (@(posedge sys_clk) disable iff (rst)
    (release_pulse != '0) |-> release_pulse == $past(grant))
    else $error("release to wrong port");
  chk_word_inhibit: assert property (@(posedge sys_clk) disable iff (rst)
    $past(supply_s2) |-> !mem_word_drive)
    else $error("word drive during fail");
  chk_wrap_range: assert property (@(posedge sys_clk) disable iff (rst)
    mem_start && (banks_installed == BANK_W'(1)) |-> mem_addr < ADDR_W'(BANK_WORDS))
    else $error("address outside one bank");
  chk_start_addr: assert property (@(posedge sys_clk) disable iff (rst)
    mem_start && (banks_installed >= BANK_W'(MAX_BANKS)) |-> mem_addr == $past(sel_addr))
    else $error("owner address not routed");

  // Data path and status
  chk_ready_time: assert property (@(posedge sys_clk) disable iff (rst)
    mem_start && !owner_write |-> ##80 (data_ready != '0))
    else $error("late data");
  chk_ready_owner: assert property (@(posedge sys_clk) disable iff (rst)
    (data_ready != '0) |-> data_ready == grant && !owner_write)
    else $error("data ready to wrong port");
  chk_read_word: assert property (@(posedge sys_clk) disable iff (rst)
    (data_ready != '0) |-> read_data == DATA_W'($past(sense_s2)))
    else $error("read word not the sensed word");
  chk_write_word: assert property (@(posedge sys_clk) disable iff (rst)
    strobe && (tick == TICK_SENSE) && owner_write |=> ^data_reg)
    else $error("write word without odd parity");
  chk_write_parity: assert property (@(posedge sys_clk) disable iff (rst)
    (mem_bit_drive != '0) |-> ^mem_bit_drive || !owner_write)
    else $error("even parity written");
  chk_bit_drive: assert property (@(posedge sys_clk) disable iff (rst)
    (mem_bit_drive & ~$past(data_reg)) == '0)
    else $error("stray bit drive");
  chk_bit_idle: assert property (@(posedge sys_clk) disable iff (rst)
    (grant == '0) |=> mem_bit_drive == '0)
    else $error("bit drive while idle");
  chk_parity_set: assert property (@(posedge sys_clk) disable iff (rst)
    (data_ready != '0) && $past(parity_bad) |-> parity_error)
    else $error("bad parity not flagged");
  chk_parity_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    parity_error && !parity_clear |=> parity_error)
    else $error("parity flag lost");
  chk_jnp_mirror: assert property (@(posedge sys_clk) disable iff (rst)
    jump_if_no_parity_fault == !parity_error)
    else $error("jump flag disagrees with error flag");
  chk_halt_follow: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(stop_sequencing) |-> parity_error && $past(halt_on_parity))
    else $error("halt without error");
  chk_stop_hold: assert property (@(posedge sys_clk) disable iff (rst)
    stop_sequencing && !parity_clear |=> stop_sequencing)
    else $error("halt dropped without clear");
endmodule : core_mem_control
`default_nettype wire

// ==== core_mem_pkg.sv ====
// Constants shared by the word-memory controller and its arbiter.
// Assumes a single 100 MHz system clock with synchronous active-high reset.
package core_mem_pkg;
  localparam int DATA_W = 24;
  localparam int WORD_W = 25;
  localparam int PAR_BIT = 24;
  localparam int ADDR_W = 15;
  localparam int PORTS = 4;
  localparam int BANK_WORDS = 4096;
  localparam int MAX_BANKS = 8;
  localparam int BANK_W = 4;
  localparam int SYS_CLK_MHZ = 100;
  localparam int MEM_CLK_MHZ = 10;
  localparam int CYCLE_NS = 1600;
  localparam int ACCESS_NS = 800;
  localparam int TICK_DIV = SYS_CLK_MHZ / MEM_CLK_MHZ;
  localparam int CYCLE_TICKS = CYCLE_NS * MEM_CLK_MHZ / 1000;
  localparam int ACCESS_TICKS = ACCESS_NS * MEM_CLK_MHZ / 1000;
  localparam int TICK_W = 5;
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);
  localparam logic [TICK_W-1:0] TICK_SENSE = TICK_W'(ACCESS_TICKS - 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CYCLE_TICKS - 1);
  localparam logic [TICK_W-1:0] TICK_ZERO = 5'h00;
  typedef enum logic {DIR_READ, DIR_WRITE} dir_t;
endpackage : core_mem_pkg

// ==== core_mem_arbiter.sv ====
// Fixed-priority grant for the four requesters of the word memory.
// Assumes requests are already synchronised; port 0 is the arithmetic unit.
`timescale 1ns/1ps
`default_nettype none
module core_mem_arbiter
  import core_mem_pkg::*;
#(
  parameter int N = PORTS
) (
  // Requests and one-hot choice
  input wire logic [N-1:0] req,
  output logic [N-1:0] pick,
  output logic any
);
  always_comb begin
    pick = '0;
    any = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        pick = '0;
        pick[i] = 1'b1;
        any = 1'b1;
      end
    end
  end
endmodule : core_mem_arbiter
`default_nettype wire

// ==== core_mem_storage.sv ====
// Behavioural storage module that answers the word-memory controller.
// Assumes the controller's registered storage outputs and one clock.
`timescale 1ns/1ps
`default_nettype none
module core_mem_storage
  import core_mem_pkg::*;
(
  // Controller side
  input wire logic sys_clk,
  input wire logic mem_start,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_word_drive,
  input wire logic [WORD_W-1:0] mem_bit_drive,
  output logic [WORD_W-1:0] mem_sense,
  // Bench side
  input wire logic [WORD_W-1:0] flip,
  output logic [ADDR_W-1:0] last_addr,
  output logic [WORD_W-1:0] last_word
);
  logic [WORD_W-1:0] core [0:(1<<ADDR_W)-1];
  logic toggle;
  always_ff @(posedge sys_clk) begin
    toggle <= (toggle === 1'b1) ? 1'b0 : 1'b1;
    if (mem_start) last_addr <= mem_addr;
    // A nonzero bit drive replaces the whole word, so only driven ones end up stored
    if (mem_word_drive && mem_bit_drive != '0) begin
      core[last_addr] <= mem_bit_drive;
      last_word <= mem_bit_drive;
    end
  end
  // Without word drive the sense lines carry noise, never the old word
  assign mem_sense = mem_word_drive ? core[last_addr] ^ flip : {WORD_W{toggle}};
endmodule : core_mem_storage
`default_nettype wire

// ==== core_memory_control_parity_test.sv ====
// Self-checking bench for the word-memory controller.
// Assumes the storage model is compiled first; ports 0..3 all used.
`timescale 1ns/1ps
`default_nettype none
module core_memory_control_parity_test import core_mem_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [PORTS-1:0] req = '0, req_write = '0, grant, data_ready, release_pulse;
  logic [PORTS*ADDR_W-1:0] req_addr = '0;
  logic [PORTS*DATA_W-1:0] req_wdata = '0;
  logic [DATA_W-1:0] read_data;
  logic [BANK_W-1:0] banks_installed = 4'h8;
  logic halt_on_parity = 1'b0, supply_fail = 1'b0, parity_clear = 1'b0;
  logic parity_error, jump_if_no_parity_fault, stop_sequencing, mem_start, mem_word_drive;
  logic [ADDR_W-1:0] mem_addr, last_addr;
  logic [WORD_W-1:0] mem_bit_drive, mem_sense, last_word, flip = '0;
  int failures = 0, checks_done = 0, wd;
  always #5 sys_clk = ~sys_clk;
  core_mem_control core_mem_control_i (.sys_clk, .rst, .req, .req_write, .req_addr,
    .req_wdata, .grant, .data_ready, .release_pulse, .read_data, .banks_installed,
    .halt_on_parity, .supply_fail, .parity_clear, .parity_error, .jump_if_no_parity_fault,
    .stop_sequencing, .mem_start, .mem_addr, .mem_word_drive, .mem_bit_drive, .mem_sense);
  core_mem_storage core_mem_storage_i (.sys_clk, .mem_start, .mem_addr, .mem_word_drive,
    .mem_bit_drive, .mem_sense, .flip, .last_addr, .last_word);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    if (failures == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // One whole storage cycle on port p, timed from the grant
  task automatic xfer(input int p, input logic wr, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
    int n;
    int t_dr;
    int other;
    req_write[p] = wr;
    req_addr[p*ADDR_W +: ADDR_W] = a;
    req_wdata[p*DATA_W +: DATA_W] = d;
    req[p] = 1'b1;
    n = 0;
    while (grant[p] !== 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    check("grant", grant[p], 1'b1);
    n = 0;
    t_dr = 0;
    other = 0;
    wd = 0;
    while (release_pulse[p] !== 1'b1 && n < 300) begin
      @(negedge sys_clk);
      n++;
      if (n == 1) check("mem_start", mem_start, 1'b1);
      if (data_ready[p] === 1'b1) t_dr = n;
      if ((grant & ~(4'h1 << p)) != 4'h0) other++;
      if (mem_word_drive === 1'b1) wd++;
    end
    // Request held until release, then dropped
    req[p] = 1'b0;
    check("ready_at", t_dr, wr ? 0 : 81);
    check("release_at", n, 161);
    check("exclusive", other, 0);
    repeat (3) @(negedge sys_clk);
    check("regrant", grant[p], 1'b0);
  endtask : xfer
  task automatic t_idle;
    int busy;
    busy = 0;
    repeat (20) begin
      @(negedge sys_clk);
      if (mem_start !== 1'b0 || grant !== 4'h0) busy++;
    end
    check("idle", busy, 0);
    check("jnp_reset", jump_if_no_parity_fault, 1'b1);
  endtask : t_idle
  task automatic t_store;
    logic [DATA_W-1:0] vals [2] = '{24'h000000, 24'h000001};
    foreach (vals[i]) begin
      xfer(i, DIR_WRITE, 15'h7fff, vals[i]);
      check("word", last_word, {~^vals[i], vals[i]});
      xfer(3 - i, DIR_READ, 15'h7fff, 24'h000000);
      check("rdata", read_data, vals[i]);
      check("wdrive", wd > 0, 1'b1);
    end
    check("no_perr", parity_error, 1'b0);
  endtask : t_store
  task automatic t_priority;
    req_write[2] = 1'b0;
    req_addr[2*ADDR_W +: ADDR_W] = 15'h0123;
    req[2] = 1'b1;
    // Raised in the same step as port 2, so port 0 must win
    xfer(0, DIR_WRITE, 15'h0123, 24'h5a5a5a);
    xfer(2, DIR_READ, 15'h0123, 24'h000000);
    check("prio_data", read_data, 24'h5a5a5a);
  endtask : t_priority
  task automatic t_parity;
    flip = 25'h1000000;
    xfer(1, DIR_READ, 15'h0123, 24'h000000);
    check("perr", parity_error, 1'b1);
    check("jnp", jump_if_no_parity_fault, 1'b0);
    check("stop_off", stop_sequencing, 1'b0);
    flip = '0;
    parity_clear = 1'b1;
    @(negedge sys_clk);
    parity_clear = 1'b0;
    @(negedge sys_clk);
    check("cleared", parity_error, 1'b0);
    // The restore wrote the bad word back, so it fails again
    halt_on_parity = 1'b1;
    xfer(1, DIR_READ, 15'h0123, 24'h000000);
    check("stop_on", stop_sequencing, 1'b1);
    check("perr2", parity_error, 1'b1);
  endtask : t_parity
  task automatic t_wrap;
    banks_installed = 4'h1;
    xfer(3, DIR_WRITE, 15'h1005, 24'h00c0de);
    check("wrap1", last_addr, 15'h0005);
    banks_installed = 4'h2;
    xfer(0, DIR_WRITE, 15'h3005, 24'h000777);
    check("wrap2", last_addr, 15'h1005);
    banks_installed = 4'h8;
    xfer(2, DIR_READ, 15'h0005, 24'h000000);
    check("wrap_data", read_data, 24'h00c0de);
  endtask : t_wrap
  task automatic t_supply;
    supply_fail = 1'b1;
    xfer(1, DIR_READ, 15'h0005, 24'h000000);
    check("inhibit", wd, 0);
    supply_fail = 1'b0;
    repeat (5) @(negedge sys_clk);
  endtask : t_supply
  initial begin
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    t_idle();
    t_store();
    t_priority();
    t_parity();
    t_wrap();
    t_supply();
    tally_and_finish();
  end
  // About 2,000 cycles are expected; this allows ten times that
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end
endmodule : core_memory_control_parity_test
`default_nettype wire
